/* atp_pkg.sv */
// Package: constants, register map and state types for the axis profiler
package atp_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ           = 10_000_000;
  localparam int SAMPLE_PERIOD_US = 1000;
  localparam int TICK_CYCLES      = (CLK_HZ / 1_000_000) * SAMPLE_PERIOD_US;
  localparam int VEL_WINDOW_MS    = 250;
  localparam int VEL_WINDOW_TICKS = (VEL_WINDOW_MS * 1000) / SAMPLE_PERIOD_US;
  localparam int VEL_SCALE        = 1000 / VEL_WINDOW_MS;

  // ----------------------------------------------------------------------
  // Geometry and register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int NAX    = 4;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_MODE   = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_BEGIN  = 10'h004;
  localparam logic [ADDR_W-1:0] ADDR_STOP   = 10'h008;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 10'h00C;
  localparam int AXIS_SHIFT = 6;
  localparam logic [5:0] OFS_ABS_TARGET = 6'h00;
  localparam logic [5:0] OFS_REL_DIST   = 6'h04;
  localparam logic [5:0] OFS_SPEED      = 6'h08;
  localparam logic [5:0] OFS_ACCEL      = 6'h0C;
  localparam logic [5:0] OFS_DECEL      = 6'h10;
  localparam logic [5:0] OFS_JOG_VEL    = 6'h14;
  localparam logic [5:0] OFS_INCR       = 6'h18;
  localparam logic [5:0] OFS_SMOOTH_TC  = 6'h1C;
  localparam logic [5:0] OFS_MEAS_VEL   = 6'h20;
  localparam logic [5:0] OFS_CMD_POS    = 6'h24;
  localparam int STAT_INPOS_LSB = 8;
  localparam int STAT_IPREJ_LSB = 16;

  // ----------------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [31:0] INPOS_BAND  = 32'h0000_0002;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef logic [NAX-1:0][31:0] atp_word_arr_t;

  typedef enum logic [1:0] {PH_IDLE, PH_POS, PH_JOG, PH_STOP} atp_phase_e;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } atp_axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } atp_axil_rsp_s;

  typedef struct packed {
    atp_phase_e         phase;
    logic               fwd;
    logic [31:0]        vel;
    logic signed [31:0] pos;
    logic signed [31:0] target;
    logic signed [31:0] rel;
    logic [31:0]        speed;
    logic [31:0]        accel;
    logic [31:0]        decel;
    logic signed [31:0] jog;
    logic [3:0]         tc;
    logic signed [31:0] smooth;
    logic               ip_rej;
    logic [15:0]        win_cnt;
    logic signed [31:0] win_start;
    logic signed [31:0] meas_vel;
  } atp_axis_s;

  typedef struct packed {
    logic              aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic              w_have;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [NAX-1:0]    jog_mode;
    logic [31:0]       tick_cnt;
    logic              tick;
  } atp_top_s;

  function automatic logic [31:0] atp_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

/* atp_axis_trajectory_profiler.sv */
// Multi-axis trajectory profiler with an AXI4-Lite register slave
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
// ------------------------------------------------------------------------
// Overview of operation
// RQ1: Begin builds trapezoid or triangle toward target
// RQ2: New commanded position every sample period
// RQ3: Profile end means done; next command accepted
// RQ4: Begin per axis; empty selection starts all
// RQ5: Speed and acceleration changes apply immediately
// RQ6: Host keeps decel and target while moving
// RQ7: Stop ramps down at deceleration rate
// RQ8: Same-direction increment extends target while moving
// RQ9: Increment at rest equals relative load plus begin
// RQ10: Brake early when slew unreachable, stop exact
// RQ11: Target readback destination or commanded position
// RQ12: Acceleration, deceleration and speed read back
// RQ13: Profiler-done and in-position wait flags
// RQ14: Per-axis smoothing time constant on output
// RQ15: Jog direction from sign of jog velocity
// RQ16: Jog ramps up, holds until change or stop
// RQ17: Jog speed change ramps, never steps
// RQ18: Jog increment shifts commanded position at once
// RQ19: Jog velocity integrated into position each tick
// RQ20: Measured velocity averaged over fixed window
// RQ21: Profile state advances only on sample tick
// ------------------------------------------------------------------------
module atp_axis_trajectory_profiler
  import atp_pkg::*;
#(
  parameter int P_TICK_CYCLES = TICK_CYCLES
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rstn,
  input  wire atp_axil_req_s i_axil,
  output atp_axil_rsp_s      o_axil,
  input  wire atp_word_arr_t i_act_pos,
  output atp_word_arr_t      o_cmd_pos,
  output logic               o_cmd_strobe,
  output logic [NAX-1:0]     o_profiler_done_wait,
  output logic [NAX-1:0]     o_in_position_wait
);

  // ----------------------------------------------------------------------
  // Bus slave and sample tick
  // ----------------------------------------------------------------------
  atp_top_s          top_q;
  atp_top_s          top_d;
  logic              wr_go;
  logic [NAX-1:0]    begin_sel;
  logic [NAX-1:0]    stop_sel;
  logic [NAX-1:0]    ax_wr;
  logic [5:0]        wr_ofs;
  logic [5:0]        rd_ofs;
  logic [NAX-1:0]    ax_done;
  logic [NAX-1:0]    ax_inpos;
  logic [NAX-1:0]    ax_iprej;
  logic [NAX-1:0]    ax_rd_ok;
  atp_word_arr_t     ax_rd;
  logic [31:0]       rd_word;
  logic              rd_ok;
  logic [ADDR_W-1:0] wr_idx;
  logic [ADDR_W-1:0] rd_idx;

  assign wr_go  = top_q.aw_have && top_q.w_have && !top_q.bvalid;
  assign wr_ofs = top_q.awaddr[5:0];
  assign rd_ofs = i_axil.araddr[5:0];
  assign wr_idx = top_q.awaddr >> AXIS_SHIFT;
  assign rd_idx = i_axil.araddr >> AXIS_SHIFT;

  // Empty selection means every axis
  always_comb begin
    begin_sel = '0;
    stop_sel  = '0;
    if (wr_go && top_q.awaddr == ADDR_BEGIN) begin
      begin_sel = (top_q.wdata[NAX-1:0] == '0) ? '1
                                               : top_q.wdata[NAX-1:0]; // see RQ4
    end
    if (wr_go && top_q.awaddr == ADDR_STOP) begin
      stop_sel = (top_q.wdata[NAX-1:0] == '0) ? '1 : top_q.wdata[NAX-1:0];
    end
    for (int a = 0; a < NAX; a++) begin
      ax_wr[a] = wr_go && (wr_idx == ADDR_W'(a + 1));
    end
  end

  always_comb begin
    rd_word = RST_WORD;
    rd_ok   = 1'b1;
    if (i_axil.araddr == ADDR_MODE) begin
      rd_word[NAX-1:0] = top_q.jog_mode;
    end else if (i_axil.araddr == ADDR_STATUS) begin
      rd_word[NAX-1:0]                  = ax_done;
      rd_word[STAT_INPOS_LSB +: NAX]    = ax_inpos;
      rd_word[STAT_IPREJ_LSB +: NAX]    = ax_iprej;
    end else if (i_axil.araddr == ADDR_BEGIN ||
                 i_axil.araddr == ADDR_STOP) begin
      rd_word = RST_WORD;
    end else if (rd_idx >= ADDR_W'(1) && rd_idx <= ADDR_W'(NAX)) begin
      rd_word = ax_rd[rd_idx[1:0] - 2'd1];
      rd_ok   = ax_rd_ok[rd_idx[1:0] - 2'd1];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_comb begin
    top_d      = top_q;
    top_d.tick = 1'b0;
    if (top_q.tick_cnt == 32'(P_TICK_CYCLES - 1)) begin
      top_d.tick_cnt = '0;
      top_d.tick     = 1'b1; // see RQ21
    end else begin
      top_d.tick_cnt = top_q.tick_cnt + 32'd1;
    end
    if (i_axil.awvalid && !top_q.aw_have) begin
      top_d.aw_have = 1'b1;
      top_d.awaddr  = i_axil.awaddr;
    end
    if (i_axil.wvalid && !top_q.w_have) begin
      top_d.w_have = 1'b1;
      top_d.wdata  = i_axil.wdata;
      top_d.wstrb  = i_axil.wstrb;
    end
    if (wr_go) begin
      top_d.aw_have = 1'b0;
      top_d.w_have  = 1'b0;
      top_d.bvalid  = 1'b1;
      top_d.bresp   = RESP_OKAY;
      if (top_q.awaddr == ADDR_MODE) begin
        top_d.jog_mode = NAX'(atp_merge(32'(top_q.jog_mode), top_q.wdata,
                                        top_q.wstrb));
      end else if (!(top_q.awaddr == ADDR_BEGIN ||
                     top_q.awaddr == ADDR_STOP ||
                     top_q.awaddr == ADDR_STATUS ||
                     (|ax_wr && wr_ofs <= OFS_CMD_POS))) begin
        top_d.bresp = RESP_SLVERR;
      end
    end
    if (top_q.bvalid && i_axil.bready) begin
      top_d.bvalid = 1'b0;
    end
    if (i_axil.arvalid && !top_q.rvalid) begin
      top_d.rvalid = 1'b1;
      top_d.rdata  = rd_word;
      top_d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (top_q.rvalid && i_axil.rready) begin
      top_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      top_q <= '0;
    end else begin
      top_q <= top_d;
    end
  end

  assign o_axil.awready = !top_q.aw_have;
  assign o_axil.wready  = !top_q.w_have;
  assign o_axil.bvalid  = top_q.bvalid;
  assign o_axil.bresp   = top_q.bresp;
  assign o_axil.arready = !top_q.rvalid;
  assign o_axil.rvalid  = top_q.rvalid;
  assign o_axil.rdata   = top_q.rdata;
  assign o_axil.rresp   = top_q.rresp;
  assign o_cmd_strobe   = top_q.tick;
  assign o_profiler_done_wait = ax_done;
  assign o_in_position_wait   = ax_inpos;

  // ----------------------------------------------------------------------
  // Per-axis profiler
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < NAX; g++) begin : g_axis
    atp_axis_s          ax_q;
    atp_axis_s          ax_d;
    logic [31:0]        wv;
    logic signed [31:0] act;
    logic signed [31:0] err;
    logic               moving;

    assign act    = i_act_pos[g];
    assign moving = ax_q.phase != PH_IDLE;
    assign wv     = atp_merge(RST_WORD, top_q.wdata, top_q.wstrb);
    assign err    = act - ax_q.smooth;
    // Profiler done only once smoothing has caught up
    assign ax_done[g]  = !moving && ax_q.smooth == ax_q.pos; // see RQ13
    assign ax_inpos[g] = ax_done[g] &&
                         ((err < 0 ? -err : err) <= $signed(INPOS_BAND));
    assign ax_iprej[g] = ax_q.ip_rej;
    assign o_cmd_pos[g] = ax_q.smooth;

    always_comb begin
      ax_rd[g]    = RST_WORD;
      ax_rd_ok[g] = 1'b1;
      unique case (rd_ofs)
        OFS_ABS_TARGET: ax_rd[g] = moving ? ax_q.target
                                          : ax_q.smooth; // see RQ11
        OFS_REL_DIST:   ax_rd[g] = ax_q.rel; // see RQ11
        OFS_SPEED:      ax_rd[g] = ax_q.speed; // see RQ12
        OFS_ACCEL:      ax_rd[g] = ax_q.accel; // see RQ12
        OFS_DECEL:      ax_rd[g] = ax_q.decel; // see RQ12
        OFS_JOG_VEL:    ax_rd[g] = ax_q.jog;
        OFS_INCR:       ax_rd[g] = RST_WORD;
        OFS_SMOOTH_TC:  ax_rd[g] = 32'(ax_q.tc);
        OFS_MEAS_VEL:   ax_rd[g] = ax_q.meas_vel;
        OFS_CMD_POS:    ax_rd[g] = ax_q.smooth;
        default:        ax_rd_ok[g] = 1'b0;
      endcase
    end

    always_comb begin
      logic signed [31:0] rem;
      logic [63:0]        brake_need;
      logic [63:0]        brake_have;
      logic [31:0]        vn;
      logic [31:0]        want;
      logic               want_fwd;
      logic               brake;
      rem        = ax_q.fwd ? ax_q.target - ax_q.pos : ax_q.pos - ax_q.target;
      rem        = (rem < 0) ? 32'sd0 : rem;
      brake_need = 64'(ax_q.decel) * 64'({rem, 1'b0});
      brake_have = 64'(ax_q.vel) * (64'(ax_q.vel) + 64'(ax_q.decel));
      brake      = brake_need <= brake_have;
      want_fwd   = !ax_q.jog[31]; // see RQ15
      want       = want_fwd ? ax_q.jog : -ax_q.jog;
      vn         = ax_q.vel;
      ax_d       = ax_q;

      if (top_q.tick) begin // see RQ21
        unique case (ax_q.phase)
          PH_IDLE: vn = '0;
          PH_POS: begin
            // Braking test uses live velocity and decel values; the ramps use live speed and accel, see RQ5
            if (brake) begin // see RQ10
              vn = (ax_q.vel > ax_q.decel) ? ax_q.vel - ax_q.decel : '0;
            end else if (ax_q.vel < ax_q.speed) begin // see RQ1
              vn = (ax_q.speed - ax_q.vel > ax_q.accel)
                   ? ax_q.vel + ax_q.accel : ax_q.speed;
            end else if (ax_q.vel > ax_q.speed) begin // see RQ5
              vn = (ax_q.vel - ax_q.speed > ax_q.decel)
                   ? ax_q.vel - ax_q.decel : ax_q.speed;
            end
            // Creep keeps a rounding shortfall from stalling the axis
            if (vn == '0) begin
              vn = 32'd1;
            end
            if ($signed(vn) >= rem) begin // see RQ3
              ax_d.pos   = ax_q.target; // see RQ10
              vn         = '0;
              ax_d.phase = PH_IDLE;
            end
          end
          PH_JOG: begin
            if (want_fwd != ax_q.fwd && ax_q.vel != '0) begin
              vn = (ax_q.vel > ax_q.decel) ? ax_q.vel - ax_q.decel : '0;
            end else if (ax_q.vel < want) begin // see RQ16
              ax_d.fwd = want_fwd;
              vn = (want - ax_q.vel > ax_q.accel)
                   ? ax_q.vel + ax_q.accel : want; // see RQ17
            end else if (ax_q.vel > want) begin
              vn = (ax_q.vel - want > ax_q.decel)
                   ? ax_q.vel - ax_q.decel : want; // see RQ17
            end
          end
          PH_STOP: begin
            vn = (ax_q.vel > ax_q.decel) ? ax_q.vel - ax_q.decel : '0; // see RQ7
            if (vn == '0) begin
              ax_d.phase = PH_IDLE;
            end
          end
        endcase
        ax_d.vel = vn;
        if (ax_d.phase != PH_IDLE || ax_q.phase == PH_STOP) begin
          ax_d.pos = ax_d.fwd ? ax_q.pos + $signed(vn)
                              : ax_q.pos - $signed(vn); // see RQ2, RQ19
        end
        if (ax_q.phase == PH_STOP && vn == '0) begin
          ax_d.target = ax_d.pos;
        end
        // Snap once the shifted step dies out, else done never rises
        if (((ax_q.pos - ax_q.smooth) >>> ax_q.tc) == 0) begin
          ax_d.smooth = ax_q.pos; // see RQ14
        end else begin
          ax_d.smooth = ax_q.smooth +
                        ((ax_q.pos - ax_q.smooth) >>> ax_q.tc); // see RQ14
        end
        if (ax_q.win_cnt == 16'(VEL_WINDOW_TICKS - 1)) begin
          ax_d.win_cnt   = '0;
          ax_d.win_start = act;
          ax_d.meas_vel  = 32'((act - ax_q.win_start) * VEL_SCALE); // see RQ20
        end else begin
          ax_d.win_cnt = ax_q.win_cnt + 16'd1;
        end
      end

      if (ax_wr[g]) begin
        unique case (wr_ofs)
          // Target writes ignored while moving, see RQ6
          OFS_ABS_TARGET: if (!moving) ax_d.target = wv;
          OFS_REL_DIST: begin
            if (!moving) begin
              ax_d.rel    = wv;
              ax_d.target = ax_q.pos + $signed(wv);
            end
          end
          OFS_SPEED:     ax_d.speed = atp_merge(ax_q.speed, top_q.wdata,
                                                top_q.wstrb); // see RQ5
          OFS_ACCEL:     ax_d.accel = atp_merge(ax_q.accel, top_q.wdata,
                                                top_q.wstrb); // see RQ5
          OFS_DECEL:     if (!moving) ax_d.decel = wv; // see RQ6
          OFS_JOG_VEL:   ax_d.jog = wv;
          OFS_SMOOTH_TC: ax_d.tc = wv[3:0];
          OFS_INCR: begin
            ax_d.rel = wv;
            if (top_q.jog_mode[g]) begin
              ax_d.pos = ax_d.pos + $signed(wv); // see RQ18
            end else if (ax_q.phase == PH_POS) begin
              if ($signed(wv) == 0 || (ax_q.fwd == !wv[31])) begin
                ax_d.target = ax_q.target + $signed(wv); // see RQ8
              end else begin
                ax_d.ip_rej = 1'b1; // see RQ8
              end
            end else if (!moving) begin
              ax_d.target = ax_q.pos + $signed(wv); // see RQ9
              ax_d.fwd    = !wv[31];
              ax_d.phase  = PH_POS; // see RQ9
              ax_d.ip_rej = 1'b0;
            end
          end
          default: ;
        endcase
      end

      if (begin_sel[g] && !moving) begin // see RQ3, RQ4
        ax_d.ip_rej = 1'b0;
        if (top_q.jog_mode[g]) begin
          ax_d.phase = PH_JOG; // see RQ16
          ax_d.fwd   = want_fwd; // see RQ15
        end else begin
          ax_d.phase = PH_POS; // see RQ1
          ax_d.fwd   = ax_q.target >= ax_q.pos;
        end
      end
      if (stop_sel[g] && (ax_q.phase == PH_POS || ax_q.phase == PH_JOG)) begin
        ax_d.phase = PH_STOP; // see RQ7
      end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
        ax_q <= '0;
      end else begin
        ax_q <= ax_d;
      end
    end
  end

endmodule

/* atp_profiler_assertions.sv */
// Port-level assertions for the axis trajectory profiler
`timescale 1ns/100ps
module atp_profiler_assertions
  import atp_pkg::*;
#(
  parameter int P_TICK_CYCLES = TICK_CYCLES
) (
  input wire logic           i_mclk,
  input wire logic           i_rstn,
  input wire atp_axil_req_s  i_axil,
  input wire atp_axil_rsp_s  o_axil,
  input wire atp_word_arr_t  i_act_pos,
  input wire atp_word_arr_t  o_cmd_pos,
  input wire logic           o_cmd_strobe,
  input wire logic [NAX-1:0] o_profiler_done_wait,
  input wire logic [NAX-1:0] o_in_position_wait
);
  localparam int TK = P_TICK_CYCLES;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  logic [31:0] gap_q;

  // Cycles since last strobe; all ones at reset so the first period counts
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      gap_q <= '1;
    end else begin
      gap_q <= o_cmd_strobe ? 32'h0 : gap_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------------
  sequence s_wr_taken;
    i_axil.awvalid && o_axil.awready && i_axil.wvalid && o_axil.wready;
  endsequence
  sequence s_rd_taken;
    i_axil.arvalid && o_axil.arready;
  endsequence

  a_wr_latency: assert property (s_wr_taken |=>
    !o_axil.awready ##[0:1] o_axil.bvalid)
    else $error("write response late or address not held");
  a_rd_latency: assert property (s_rd_taken |=> o_axil.rvalid)
    else $error("read data not one cycle after address");
  a_bvalid_release: assert property (o_axil.bvalid && i_axil.bready |=>
    !o_axil.bvalid)
    else $error("write response not released");
  a_rvalid_release: assert property (o_axil.rvalid && i_axil.rready |=>
    !o_axil.rvalid)
    else $error("read data not released");
  a_rd_refuse: assert property (o_axil.rvalid |-> !o_axil.arready)
    else $error("read address taken while data pending");

  // ----------------------------------------------------------------------
  // Sample tick and profile outputs
  // ----------------------------------------------------------------------
  a_strobe_pulse: assert property (o_cmd_strobe |=> !o_cmd_strobe)
    else $error("sample strobe wider than one cycle");
  a_strobe_period: assert property
    (o_cmd_strobe == (gap_q == 32'(TK - 1)))
    else $error("sample strobe period wrong");
  a_done_pos_hold: assert property (o_profiler_done_wait[0] &&
    $past(o_profiler_done_wait[0]) |-> $stable(o_cmd_pos[0]))
    else $error("position moved while profile done");
  a_inpos_done: assert property
    ((o_in_position_wait & ~o_profiler_done_wait) == 4'h0)
    else $error("in position without profile done");
endmodule

bind atp_axis_trajectory_profiler atp_profiler_assertions #(
  .P_TICK_CYCLES(P_TICK_CYCLES)
) u_chk (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_axil(i_axil), .o_axil(o_axil),
  .i_act_pos(i_act_pos), .o_cmd_pos(o_cmd_pos),
  .o_cmd_strobe(o_cmd_strobe),
  .o_profiler_done_wait(o_profiler_done_wait),
  .o_in_position_wait(o_in_position_wait)
);

/* atp_servo_model.sv */
// Behavioural servo loop that follows the commanded positions
`timescale 1ns/100ps
module atp_servo_model
  import atp_pkg::*;
(
  input  wire logic          i_mclk,
  input  wire logic          i_rstn,
  input  wire logic          i_slow,
  input  wire logic          i_strobe,
  input  wire atp_word_arr_t i_cmd_pos,
  output atp_word_arr_t      o_act_pos
);
  // Slow loop settles only once per sample period, a tick behind
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_act_pos <= '0;
    end else if (!i_slow || i_strobe) begin
      o_act_pos <= i_cmd_pos;
    end
  end
endmodule

/* atp_axis_trajectory_profiler_tb_top.sv */
// Self-checking bench for the axis trajectory profiler
`timescale 1ns/100ps
module atp_axis_trajectory_profiler_tb_top
  import atp_pkg::*;
;
  localparam int TK = 8;
  logic          i_mclk;
  logic          i_rstn;
  logic          slow;
  logic          strobe;
  logic [3:0]    done_w;
  logic [3:0]    inpos_w;
  logic [31:0]   rdat;
  logic [31:0]   p0;
  logic [1:0]    resp;
  atp_axil_req_s req;
  atp_axil_rsp_s rsp;
  atp_word_arr_t act_pos;
  atp_word_arr_t cmd_pos;
  int            fails;
  int            checks;

  atp_axis_trajectory_profiler #(.P_TICK_CYCLES(TK)) i_dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_axil(req), .o_axil(rsp),
    .i_act_pos(act_pos), .o_cmd_pos(cmd_pos), .o_cmd_strobe(strobe),
    .o_profiler_done_wait(done_w), .o_in_position_wait(inpos_w));
  atp_servo_model i_servo (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_slow(slow), .i_strobe(strobe),
    .i_cmd_pos(cmd_pos), .o_act_pos(act_pos));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  function automatic logic [9:0] ax_a(input int a, input logic [5:0] o);
    return 10'((a + 1) << AXIS_SHIFT) | {4'h0, o};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    req <= '{awaddr: a, awvalid: 1'b1, wdata: d, wstrb: 4'hF,
             wvalid: 1'b1, bready: 1'b1, default: '0};
    do begin
      @(posedge i_mclk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge i_mclk);
    req <= '{araddr: a, arvalid: 1'b1, rready: 1'b1, default: '0};
    do begin
      @(posedge i_mclk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rdat = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  // Returns once the new sample-period position has landed
  task automatic tick();
    @(posedge i_mclk);
    while (strobe !== 1'b1) begin
      @(posedge i_mclk);
    end
    @(posedge i_mclk);
    #1;
  endtask
  task automatic wait_done(input int ax);
    while (done_w[ax] !== 1'b1) begin
      @(posedge i_mclk);
    end
    #1;
  endtask
  task automatic setup(input int ax, input logic [31:0] spd);
    wr(ax_a(ax, OFS_SPEED), spd);
    wr(ax_a(ax, OFS_ACCEL), 32'h1);
    wr(ax_a(ax, OFS_DECEL), 32'h1);
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    rd(ADDR_STATUS);
    chk("status rst", rdat, 32'h0000_0F0F);
    rd(ax_a(1, OFS_SPEED));
    chk("speed rst", rdat, RST_WORD);
    for (int i = 0; i < 3; i++) begin
      wr(ax_a(1, OFS_SPEED + 6'(4 * i)), 32'(i + 3));
      rd(ax_a(1, OFS_SPEED + 6'(4 * i)));
      chk("setting", rdat, 32'(i + 3));
    end
    rd(10'h3FC);
    chk("unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
    rd(ax_a(0, 6'h28));
    chk("axis hole", {30'h0, resp}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_tri_all();
    setup(2, 32'd50);
    wr(ax_a(2, OFS_SMOOTH_TC), 32'd1);
    wr(ax_a(2, OFS_REL_DIST), 32'd10);
    wr(ADDR_BEGIN, 32'h0);
    tick();
    repeat (3) tick();
    chk("smoothed", cmd_pos[2], 32'd6);
    wait_done(2);
    chk("tri end", cmd_pos[2], 32'd10);
    rd(ax_a(2, OFS_REL_DIST));
    chk("rel rb", rdat, 32'd10);
  endtask
  task automatic t_trap();
    setup(0, 32'd5);
    wr(ax_a(0, OFS_ABS_TARGET), 32'd100);
    wr(ADDR_BEGIN, 32'h1);
    tick();
    rd(ax_a(0, OFS_ABS_TARGET));
    chk("dest rb", rdat, 32'd100);
    repeat (2) tick();
    wr(ax_a(0, OFS_SPEED), 32'd2);
    repeat (2) tick();
    p0 = cmd_pos[0];
    tick();
    chk("new speed", cmd_pos[0] - p0, 32'd2);
    wait_done(0);
    chk("trap end", cmd_pos[0], 32'd100);
    rd(ax_a(0, OFS_ABS_TARGET));
    chk("idle rb", rdat, 32'd100);
    chk("in pos", 32'(inpos_w[0]), 32'h1);
  endtask
  task automatic t_stop();
    setup(1, 32'd4);
    wr(ax_a(1, OFS_ABS_TARGET), 32'd1000);
    wr(ADDR_BEGIN, 32'h2);
    repeat (8) tick();
    wr(ADDR_STOP, 32'h2);
    tick();
    p0 = cmd_pos[1];
    tick();
    chk("stop ramp", cmd_pos[1] - p0, 32'd3);
    wait_done(1);
    chk("stop short", 32'(cmd_pos[1] < 32'd1000), 32'h1);
  endtask
  task automatic t_incr();
    slow = 1'b1;
    setup(3, 32'd2);
    wr(ax_a(3, OFS_INCR), 32'd20);
    wait_done(3);
    chk("idle incr", cmd_pos[3], 32'd20);
    rd(ax_a(3, OFS_REL_DIST));
    chk("incr rel", rdat, 32'd20);
    wr(ax_a(3, OFS_INCR), 32'd60);
    tick();
    wr(ax_a(3, OFS_INCR), 32'd10);
    wr(ax_a(3, OFS_INCR), 32'hFFFF_FFFB);
    rd(ax_a(3, OFS_ABS_TARGET));
    chk("incr dest", rdat, 32'd90);
    rd(ADDR_STATUS);
    chk("incr rej", 32'(rdat[STAT_IPREJ_LSB + 3]), 32'h1);
    wait_done(3);
    chk("incr end", cmd_pos[3], 32'd90);
    slow = 1'b0;
  endtask
  task automatic t_jog();
    wr(ADDR_MODE, 32'h1);
    wr(ax_a(0, OFS_JOG_VEL), 32'hFFFF_FFFD);
    wr(ADDR_BEGIN, 32'h1);
    repeat (8) tick();
    p0 = cmd_pos[0];
    tick();
    chk("jog rev", cmd_pos[0] - p0, 32'hFFFF_FFFD);
    repeat (2 * VEL_WINDOW_TICKS + 4) tick();
    rd(ax_a(0, OFS_MEAS_VEL));
    chk("meas vel", rdat, 32'(-3 * VEL_WINDOW_TICKS * VEL_SCALE));
    tick();
    p0 = cmd_pos[0];
    wr(ax_a(0, OFS_INCR), 32'd100);
    tick();
    chk("jog incr", cmd_pos[0] - p0, 32'd97);
    wr(ax_a(0, OFS_JOG_VEL), 32'd6);
    tick();
    p0 = cmd_pos[0];
    tick();
    chk("jog ramp", cmd_pos[0] - p0, 32'hFFFF_FFFE);
    wr(ADDR_STOP, 32'h1);
    wait_done(0);
    chk("jog stop", 32'(done_w[0]), 32'h1);
    wr(ADDR_MODE, 32'h0);
  endtask

  // ----------------------------------------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  initial begin
    fails = 0;
    checks = 0;
    req = '0;
    slow = 1'b0;
    i_rstn = 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rstn <= 1'b1;
    t_regs();
    t_tri_all();
    t_trap();
    t_stop();
    t_incr();
    t_jog();
    close_out();
  end
  // Full run needs about 5500 cycles; allow ample margin
  initial begin
    #6_000_000;
    fails++;
    close_out();
  end
endmodule
